// file: core/scrf_pkg.sv
/*
 * Shared constants, field layout and clock-select decoding for the
 * system clock and reset-flag block.
 * Assumes a single 100 MHz reference clock drives every module.
 */
package scrf_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] OFF_SYS_CTRL   = 8'h00; // System control
	localparam logic [7:0] OFF_CLK_MODE   = 8'h04; // Clock mode
	localparam logic [7:0] OFF_CLK_STATUS = 8'h08; // Clock status, read only
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c; // Sticky events, write one to clear
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h10; // Interrupt enables

	// ==========================================================
	// Field positions
	localparam int CTRL_IDLE_EN_BIT = 7; // Idle clock enable
	localparam int CTRL_LVR_BIT     = 2; // Low-voltage reset flag
	localparam int CTRL_CSW_BIT     = 1; // Control-register software reset flag
	localparam int CTRL_WSW_BIT     = 0; // Watchdog-register software reset flag
	localparam int MODE_HL_BIT      = 0; // High/low clock select
	localparam int MODE_DIV_LSB     = 5; // Divider select, three bits
	localparam int STAT_HS_RUN_BIT  = 0; // High-speed oscillator running
	localparam int STAT_LOW_SEL_BIT = 1; // System clock on low-speed source
	localparam int IRQ_SWITCH_BIT   = 3; // Switched to low-speed source

	// ==========================================================
	// Reset values
	localparam logic       IDLE_EN_RST = 1'b0;
	localparam logic [2:0] FLAGS_RST   = 3'h0;
	localparam logic       HL_RST      = 1'b1;
	localparam logic [2:0] DIV_RST     = 3'h0;
	localparam logic [3:0] IRQ_RST     = 4'h0;

	// ==========================================================
	// Timing
	localparam int unsigned MCLK_FREQ_KHZ  = 100000; // Reference clock
	localparam int unsigned HS_OSC_KHZ     = 8000;   // High-speed oscillator
	localparam int unsigned LS_OSC_KHZ     = 32;     // Low-speed oscillator
	localparam int unsigned LS_OSC_PERIOD_CYCLES = MCLK_FREQ_KHZ / LS_OSC_KHZ;
	localparam int unsigned HS_OSC_MIN_CYCLES    = MCLK_FREQ_KHZ / HS_OSC_KHZ;
	localparam int          PHASE_W        = 17;     // Holds MCLK_FREQ_KHZ plus a step

	// ==========================================================
	// Clock-select encoding and bus answers
	localparam logic [2:0] DIV_FIRST = 3'h2; // Lower codes pick the low-speed source
	localparam logic [3:0] DIV_TOP   = 4'h8; // Shift is DIV_TOP minus the code
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// True when the system clock is taken from the low-speed source
	function automatic logic scrf_low_selected(input logic hl, input logic [2:0] div_sel);
		return !hl && (div_sel < DIV_FIRST);
	endfunction : scrf_low_selected

	// Log2 of the high-speed division for codes 2..7 (64 down to 2)
	function automatic logic [2:0] scrf_div_shift(input logic [2:0] div_sel);
		logic [3:0] diff;
		diff = DIV_TOP - {1'b0, div_sel};
		return diff[2:0];
	endfunction : scrf_div_shift

endpackage : scrf_pkg

// file: core/scrf_sel_if.sv
/*
 * Bundle between the control registers and the clock selector.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/100ps

interface scrf_sel_if;
	logic       high_select;    // Undivided high-frequency clock chosen
	logic [2:0] divider_select; // Division or low-speed choice
	logic       run_gate;       // Low stops the system clock
	logic       sys_tick;       // One-cycle system clock enable

	modport ctrl (output high_select, divider_select, run_gate, input sys_tick);
	modport sel  (input high_select, divider_select, run_gate, output sys_tick);
endinterface : scrf_sel_if

// file: core/scrf_rc_osc.sv
/*
 * Behavioural RC oscillator: emits one-cycle ticks at FREQ_KHZ by a
 * phase accumulator on the reference clock.
 * Assumes FREQ_KHZ is below REF_KHZ and the enable comes from mclk logic.
 */
`timescale 1ns/100ps

module scrf_rc_osc
	import scrf_pkg::*;
#(
	parameter int unsigned FREQ_KHZ = HS_OSC_KHZ,
	parameter int unsigned REF_KHZ  = MCLK_FREQ_KHZ
) (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic enable,
	output logic      tick,
	output logic      running
);

	// ==========================================================
	// Phase accumulator
	localparam logic [PHASE_W-1:0] STEP = PHASE_W'(FREQ_KHZ);
	localparam logic [PHASE_W-1:0] WRAP = PHASE_W'(REF_KHZ);

	logic [PHASE_W-1:0] phase; // Fraction of one output period
	logic [PHASE_W-1:0] sum;   // Phase after this cycle's step

	assign sum = phase + STEP;

	// Stopping clears the phase, so a restart begins a whole period
	always_ff @(posedge mclk) begin
		if (reset || !enable) begin
			phase <= '0;
			tick  <= 1'b0;
		end else if (sum >= WRAP) begin
			phase <= sum - WRAP;
			tick  <= 1'b1;
		end else begin
			phase <= sum;
			tick  <= 1'b0;
		end
	end

	// Running follows the enable one cycle later
	always_ff @(posedge mclk) begin
		if (reset) begin
			running <= 1'b0;
		end else begin
			running <= enable;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// Two ticks are always at least three cycles apart
	osc_spacing_a: assert property (tick |=> !tick [*2])
		else $error("oscillator ticks too close");
	// A stopped oscillator must go quiet by the next cycle
	stop_quiet_a: assert property (!enable |=> !tick)
		else $error("oscillator ticked while stopped");

endmodule : scrf_rc_osc

// file: core/scrf_clk_sel.sv
/*
 * System clock selector: undivided high-frequency clock, its binary
 * divisions by 2..64, or the low-frequency clock; gated in idle mode.
 * Assumes tick inputs are one-cycle enables on mclk.
 */
`timescale 1ns/100ps

module scrf_clk_sel
	import scrf_pkg::*;
#(
	parameter int DIV_W = 6 // Counter width for the deepest division
) (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic hf_tick,
	input  wire logic lf_tick,
	scrf_sel_if.sel   bus
);

	// ==========================================================
	// High-frequency divider
	logic [DIV_W-1:0] div_cnt;  // Counts high-frequency ticks
	logic [DIV_W:0]   div_full; // 2^shift before trimming
	logic [DIV_W-1:0] div_mask; // Low bits that must all be ones
	logic             div_tick; // Divided clock enable
	logic             src_tick; // Chosen source before gating

	// Counter freezes while the fast oscillator is stopped
	always_ff @(posedge mclk) begin
		if (reset) begin
			div_cnt <= '0;
		end else if (hf_tick) begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	always_comb begin
		div_full = (DIV_W+1)'(1) << scrf_div_shift(bus.divider_select);
		div_mask = DIV_W'(div_full - 1'b1);
		div_tick = hf_tick && (&(div_cnt | ~div_mask));
	end

	// Source choice; the decode is shared with the register block
	always_comb begin
		if (bus.high_select) begin
			src_tick = hf_tick;
		end else if (scrf_low_selected(bus.high_select, bus.divider_select)) begin
			src_tick = lf_tick;
		end else begin
			src_tick = div_tick;
		end
	end

	// Registered output; a switch takes effect on the next tick, no glitch
	always_ff @(posedge mclk) begin
		if (reset) begin
			bus.sys_tick <= 1'b0;
		end else begin
			bus.sys_tick <= src_tick && bus.run_gate;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// Divided choices only tick on an odd count
	div_odd_a: assert property (
		bus.sys_tick && !$past(bus.high_select) && $past(bus.divider_select) >= DIV_FIRST
		|-> $past(div_cnt[0]))
		else $error("divided clock ticked on even count");
	hf_route_a: assert property (
		bus.high_select && bus.run_gate && hf_tick |=> bus.sys_tick)
		else $error("undivided clock tick lost");

	div64_c: cover property (div_tick && bus.divider_select == DIV_FIRST);

endmodule : scrf_clk_sel

// file: core/scrf_top.sv
/*
 * System clock and reset-flag control: two internal oscillators, the
 * system clock selector, idle gating, reset-cause flags and an
 * AXI4-Lite register slave with a maskable interrupt.
 * Assumes reset-event and idle inputs come from logic on mclk.
 */
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
// Summary of operation
// - Internal 8 MHz high-speed oscillator
// - Internal 32 kHz low-speed oscillator
// - Low-speed clock feeds watchdog, time base, timer
// - Low-speed oscillator always runs, never disabled
// - Select and divider fields choose system clock
// - High source fast oscillator, low source slow
// - Divisions by two through sixty-four offered
// - Low source selected stops fast oscillator
`timescale 1ns/100ps

module scrf_top
	import scrf_pkg::*;
#(
	parameter int ADDR_W = 8 // Byte address width of the register window
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Events and mode from the core
	input  wire logic              low_voltage_reset_event,
	input  wire logic              ctrl_reg_sw_reset_event,
	input  wire logic              wdt_reg_sw_reset_event,
	input  wire logic              idle_mode,
	// Clock enables and status
	output logic                   sys_clk_tick,
	output logic                   hf_clk_tick,
	output logic                   wdt_clk_tick,
	output logic                   timebase_clk_tick,
	output logic                   timer_clk_tick,
	output logic                   high_osc_running,
	output logic                   irq
);

	// ==========================================================
	// Registers and internal signals
	logic              idle_clock_enable;      // Keep clock running in idle
	logic [2:0]        reset_flags;            // lvr, control sw, watchdog sw
	logic              high_low_clock_select;  // High selects undivided source
	logic [2:0]        clock_divider_select;   // Division or low-speed code
	logic [3:0]        irq_status;             // Sticky events
	logic [3:0]        irq_mask;               // Interrupt enables
	logic              low_sel;                // Low-speed source chosen now
	logic              low_sel_q;              // Previous low_sel
	logic              hs_tick;                // High-speed oscillator tick
	logic              ls_tick;                // Low-speed oscillator tick
	logic              hs_run;                 // High-speed oscillator running
	logic [ADDR_W-1:0] wr_addr;                // Captured write address
	logic [31:0]       wr_data;                // Captured write data
	logic [3:0]        wr_strb;                // Captured byte strobes
	logic              do_write;               // Both halves held, answer free
	logic              wr_ctrl;                // Byte 0 write to system control
	logic              wr_mode;                // Byte 0 write to clock mode
	logic              wr_irq_stat;            // Byte 0 write to event status
	logic              wr_irq_mask;            // Byte 0 write to mask
	logic              wr_hit;                 // Write address is mapped
	logic [2:0]        reset_events;           // Flag events in flag order
	logic [3:0]        irq_events;             // Interrupt events
	logic [31:0]       rd_word;                // Read mux output
	logic              rd_hit;                 // Read address is mapped

	scrf_sel_if sel_bus ();

	// ==========================================================
	// Oscillators
	// Fast oscillator runs only while a high-frequency choice is active
	assign low_sel = scrf_low_selected(high_low_clock_select, clock_divider_select);

	scrf_rc_osc #(
		.FREQ_KHZ (HS_OSC_KHZ),
		.REF_KHZ  (MCLK_FREQ_KHZ)
	) u_hs_osc (
		.mclk    (mclk),
		.reset   (reset),
		.enable  (!low_sel),
		.tick    (hs_tick),
		.running (hs_run)
	);

	// No register reaches this enable: the slow oscillator cannot stop
	scrf_rc_osc #(
		.FREQ_KHZ (LS_OSC_KHZ),
		.REF_KHZ  (MCLK_FREQ_KHZ)
	) u_ls_osc (
		.mclk    (mclk),
		.reset   (reset),
		.enable  (1'b1),
		.tick    (ls_tick),
		.running ()
	);

	// ==========================================================
	// System clock selector
	assign sel_bus.high_select    = high_low_clock_select;
	assign sel_bus.divider_select = clock_divider_select;
	assign sel_bus.run_gate       = !idle_mode || idle_clock_enable;

	scrf_clk_sel #(
		.DIV_W (6)
	) u_clk_sel (
		.mclk    (mclk),
		.reset   (reset),
		.hf_tick (hs_tick),
		.lf_tick (ls_tick),
		.bus     (sel_bus.sel)
	);

	// Outputs come straight from oscillator and selector flops
	assign sys_clk_tick      = sel_bus.sys_tick;
	assign hf_clk_tick       = hs_tick;
	assign wdt_clk_tick      = ls_tick;
	assign timebase_clk_tick = ls_tick;
	assign timer_clk_tick    = ls_tick;
	assign high_osc_running  = hs_run;

	// ==========================================================
	// AXI4-Lite write channel
	// Address and data are taken in either order; ready drops while held
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_ctrl     = do_write && wr_strb[0] && wr_addr == OFF_SYS_CTRL;
	assign wr_mode     = do_write && wr_strb[0] && wr_addr == OFF_CLK_MODE;
	assign wr_irq_stat = do_write && wr_strb[0] && wr_addr == OFF_IRQ_STATUS;
	assign wr_irq_mask = do_write && wr_strb[0] && wr_addr == OFF_IRQ_MASK;
	assign wr_hit = wr_addr == OFF_SYS_CTRL || wr_addr == OFF_CLK_MODE ||
		wr_addr == OFF_CLK_STATUS || wr_addr == OFF_IRQ_STATUS || wr_addr == OFF_IRQ_MASK;

	// Address half
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			wr_addr       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			wr_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// Data half
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_wready <= 1'b1;
			wr_data      <= '0;
			wr_strb      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wr_data      <= s_axi_wdata;
			wr_strb      <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Response one cycle after both halves are held
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Control registers
	// Idle enable starts cleared so idle stops the clock by default
	always_ff @(posedge mclk) begin
		if (reset) begin
			idle_clock_enable <= IDLE_EN_RST;
		end else if (wr_ctrl) begin
			idle_clock_enable <= wr_data[CTRL_IDLE_EN_BIT];
		end
	end

	// Flags set by hardware, cleared only by a written zero; set wins
	assign reset_events = {low_voltage_reset_event, ctrl_reg_sw_reset_event,
		wdt_reg_sw_reset_event};

	always_ff @(posedge mclk) begin
		if (reset) begin
			reset_flags <= FLAGS_RST;
		end else if (wr_ctrl) begin
			reset_flags <= (reset_flags & wr_data[CTRL_LVR_BIT:CTRL_WSW_BIT])
				| reset_events;
		end else begin
			reset_flags <= reset_flags | reset_events;
		end
	end

	// Clock mode may change at any time during operation
	always_ff @(posedge mclk) begin
		if (reset) begin
			high_low_clock_select <= HL_RST;
			clock_divider_select  <= DIV_RST;
		end else if (wr_mode) begin
			high_low_clock_select <= wr_data[MODE_HL_BIT];
			clock_divider_select  <= wr_data[MODE_DIV_LSB +: 3];
		end
	end

	// ==========================================================
	// Interrupts
	always_ff @(posedge mclk) begin
		if (reset) begin
			low_sel_q <= 1'b0;
		end else begin
			low_sel_q <= low_sel;
		end
	end

	assign irq_events = {low_sel && !low_sel_q, reset_events};

	// Write one clears; a same-cycle event keeps its bit
	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_status <= IRQ_RST;
		end else if (wr_irq_stat) begin
			irq_status <= (irq_status & ~wr_data[3:0]) | irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_mask <= IRQ_RST;
		end else if (wr_irq_mask) begin
			irq_mask <= wr_data[3:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			OFF_SYS_CTRL: begin
				rd_word[CTRL_IDLE_EN_BIT]           = idle_clock_enable;
				rd_word[CTRL_LVR_BIT:CTRL_WSW_BIT]  = reset_flags;
			end
			OFF_CLK_MODE: begin
				rd_word[MODE_HL_BIT]        = high_low_clock_select;
				rd_word[MODE_DIV_LSB +: 3]  = clock_divider_select;
			end
			OFF_CLK_STATUS: begin
				rd_word[STAT_HS_RUN_BIT]  = hs_run;
				rd_word[STAT_LOW_SEL_BIT] = low_sel;
			end
			OFF_IRQ_STATUS: rd_word[3:0] = irq_status;
			OFF_IRQ_MASK:   rd_word[3:0] = irq_mask;
			default:        rd_hit = 1'b0; // Unmapped: zero data, error answer
		endcase
	end

	// Data registered on the address handshake, held until taken
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	logic [12:0] ls_gap; // Cycles since the last slow tick
	logic        ls_arm; // Low for the first cycle after reset

	// The phase restarts at reset one cycle ahead of a tick, so skip that cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			ls_gap <= '0;
			ls_arm <= 1'b0;
		end else begin
			ls_arm <= 1'b1;
			if (ls_tick || !ls_arm) begin
				ls_gap <= '0;
			end else if (ls_gap != '1) begin
				ls_gap <= ls_gap + 1'b1;
			end
		end
	end

	hs_stop_a: assert property (low_sel && $past(low_sel) |-> !hf_clk_tick)
		else $error("fast clock present while slow source selected");
	ls_alive_a: assert property (ls_gap < 13'(LS_OSC_PERIOD_CYCLES))
		else $error("slow oscillator missed a tick");
	flag_clear_a: assert property (
		wr_ctrl && !wr_data[CTRL_WSW_BIT] && !wdt_reg_sw_reset_event
		|=> !reset_flags[CTRL_WSW_BIT])
		else $error("watchdog flag not cleared by zero");
	flag_keep_a: assert property (
		wr_ctrl && wr_data[CTRL_LVR_BIT:CTRL_WSW_BIT] == 3'h7
		|=> reset_flags == ($past(reset_flags) | $past(reset_events)))
		else $error("written one changed a flag");
	flag_set_a: assert property (
		low_voltage_reset_event && ctrl_reg_sw_reset_event && wdt_reg_sw_reset_event
		|=> reset_flags == 3'h7)
		else $error("reset event did not set its flag");
	idle_stop_a: assert property (idle_mode && !idle_clock_enable |=> !sys_clk_tick)
		else $error("system clock ran in idle with enable low");
	ls_route_a: assert property (
		low_sel && sel_bus.run_gate |=> sys_clk_tick == $past(ls_tick))
		else $error("slow source not routed to system clock");
	write_resp_a: assert property (do_write |=> s_axi_bvalid ##0 !s_axi_awready)
		else $error("write not answered next cycle");

	switch_low_c: cover property (low_sel && !low_sel_q);
	flag_clear_c: cover property (wr_ctrl && reset_flags != 3'h0);
	idle_stop_c:  cover property (idle_mode && !idle_clock_enable && sel_bus.high_select);

endmodule : scrf_top

// file: verification/scrf_bench.sv
/*
 * Bench for scrf_top: AXI4-Lite master tasks, reset-event pulses, tick counters.
 * Assumes the 100 MHz mclk and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %s exp %h seen %h", n, e, g); end end

module system_clock_and_reset_flags_bench;
	import scrf_pkg::*;
	// ==========================================================
	// Signals
	logic        mclk, reset, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv, irq, idle;
	logic        st, ht, wt, tbt, tmt, hor;
	logic [2:0]  ev;     // lvr, control sw, watchdog sw
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, lf;
	logic [1:0]  br, rr;
	logic [33:0] rq[$];  // Expected {rresp, rdata}
	logic [1:0]  bq[$];  // Expected bresp
	logic [33:0] eb;
	int error_cnt, check_count, cyc, n_wdt, last, gap, a, b, c;

	scrf_top scrf_top_inst (.mclk(mclk), .reset(reset), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.low_voltage_reset_event(ev[2]), .ctrl_reg_sw_reset_event(ev[1]),
		.wdt_reg_sw_reset_event(ev[0]), .idle_mode(idle), .sys_clk_tick(st),
		.hf_clk_tick(ht), .wdt_clk_tick(wt), .timebase_clk_tick(tbt),
		.timer_clk_tick(tmt), .high_osc_running(hor), .irq(irq));

	// Pseudo-random source for upper write bits that must be ignored
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : wait_cyc

	// Counts system and fast ticks over n edges from pre-edge values, free of races
	task automatic count_ticks(input int n, output int ns, output int nh);
		ns = 0;
		nh = 0;
		repeat (n) begin
			@(posedge mclk);
			ns += int'(st === 1'b1);
			nh += int'(ht === 1'b1);
		end
	endtask : count_ticks

	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		awa <= ad; wd <= d; awv <= 1'b1; wv <= 1'b1;
		do begin
			@(posedge mclk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (!bv);
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		ara <= ad; arv <= 1'b1;
		do begin
			@(posedge mclk);
			if (arr) arv <= 1'b0;
		end while (!rv);
	endtask : rd

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// Watcher: tick counters, response checks, hang guard
	always @(posedge mclk) begin
		cyc++;
		if (st === 1'b1) begin gap = cyc - last; last = cyc; end
		if ((wt & tbt & tmt) === 1'b1) n_wdt++;
		if (bv && bre) begin eb = bq.pop_front(); `CHK("bresp", eb[1:0], br) end
		if (rv && rre) begin eb = rq.pop_front(); `CHK("rdata", eb, {rr, rdat}) end
		if (cyc == 60000) begin error_cnt++; give_verdict(); end
	end

	// ==========================================================
	// Main sequence
	initial begin
		{awv, wv, arv, idle, ev} = '0;
		{awa, ara, wd} = '0;
		bre = 1'b1; // Response readies stay high: each answer is taken at once
		rre = 1'b1;
		lf = 32'hcbaa;
		reset = 1'b1;
		wait_cyc(8);
		reset <= 1'b0;
		@(posedge mclk);
		rd(OFF_SYS_CTRL, 32'h0, RESP_OKAY);
		rd(OFF_CLK_MODE, 32'h1, RESP_OKAY);
		rd(OFF_CLK_STATUS, 32'h1, RESP_OKAY);
		`CHK("hs running", 1'b1, hor)
		// Undivided fast source: 20 ticks in every 250 cycles
		count_ticks(250, c, a);
		`CHK("hf rate", 20, a)
		`CHK("sys undivided", 20, c)
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h0, RESP_SLVERR);
		ev <= 3'h7;
		@(posedge mclk);
		ev <= 3'h0;
		lf = lfsr(lf);
		wr(OFF_SYS_CTRL, {lf[31:8], 8'h07}, RESP_OKAY);
		rd(OFF_SYS_CTRL, 32'h7, RESP_OKAY);
		`CHK("irq masked", 1'b0, irq)
		wr(OFF_IRQ_MASK, 32'h4, RESP_OKAY);
		wait_cyc(2);
		`CHK("irq set", 1'b1, irq)
		wr(OFF_IRQ_STATUS, 32'h4, RESP_OKAY);
		wait_cyc(2);
		`CHK("irq clear", 1'b0, irq)
		wr(OFF_SYS_CTRL, 32'h2, RESP_OKAY);
		rd(OFF_SYS_CTRL, 32'h2, RESP_OKAY);
		// Low-speed source stops the fast oscillator, slow ticks keep going
		wr(OFF_IRQ_MASK, 32'h8, RESP_OKAY);
		wr(OFF_CLK_MODE, 32'h0, RESP_OKAY);
		wait_cyc(2);
		rd(OFF_CLK_STATUS, 32'h2, RESP_OKAY);
		`CHK("irq switch", 1'b1, irq)
		`CHK("hs running", 1'b0, hor)
		b = n_wdt;
		count_ticks(7000, c, a);
		`CHK("hf stopped", 0, a)
		`CHK("slow ticks", 1'b1, (n_wdt - b >= 2) && (c >= 2))
		// Each division of the fast clock: spacing is 12.5 cycles times 2^(8-code)
		for (int k = 2; k < 8; k++) begin
			wr(OFF_CLK_MODE, k << 5, RESP_OKAY);
			wait_cyc(2000);
			`CHK("div gap", 25 << (7 - k), gap)
		end
		// Idle gating, first disabled then enabled
		idle <= 1'b1;
		wait_cyc(3);
		count_ticks(100, c, a);
		`CHK("idle stop", 0, c)
		wr(OFF_SYS_CTRL, 32'h82, RESP_OKAY);
		wait_cyc(3);
		count_ticks(100, c, a);
		`CHK("idle run", 4, c)
		idle <= 1'b0;
		rd(OFF_SYS_CTRL, 32'h82, RESP_OKAY);
		wait_cyc(2);
		give_verdict();
	end
endmodule : system_clock_and_reset_flags_bench
